// >>> hw/tbs_div_stage.sv
// One modulus-N divider stage of the time base chain
`timescale 1ns/1ps
module tbs_div_stage #(
	parameter int unsigned MODULUS = 2
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic arst_n,
	// Control
	input  wire logic en,
	input  wire logic clear,
	// Ticks
	input  wire logic tick_in,
	output logic      tick_out
);
	localparam int unsigned CW = (MODULUS > 2) ? $clog2(MODULUS) : 1;

	logic [CW-1:0] count_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
			tick_out  <= 1'b0;
		end else if (en) begin
			if (clear) begin
				count_reg <= '0;
				tick_out  <= 1'b0;
			end else if (tick_in) begin
				if (count_reg == CW'(MODULUS - 1)) begin
					count_reg <= '0;
					tick_out  <= 1'b1;
				end else begin
					count_reg <= count_reg + CW'(1);
					tick_out  <= 1'b0;
				end
			end else begin
				tick_out <= 1'b0;
			end
		end
	end
endmodule // tbs_div_stage

// >>> hw/tbs_pkg.sv
// Shared constants for the time base and internal status ports
package tbs_pkg;
	// Port instruction classes presented by the CPU core
	localparam logic [1:0] OP_IO_IN   = 2'h0;
	localparam logic [1:0] OP_IO_OUT  = 2'h1;
	localparam logic [1:0] OP_KEY_IN  = 2'h2;
	localparam logic [1:0] OP_KEY_OUT = 2'h3;
	// Channel operands
	localparam logic [3:0] CH_INHIBIT  = 4'h4;
	localparam logic [3:0] CH_TIMEBASE = 4'h5;
	localparam logic [3:0] CH_TEST     = 4'h7;
	// Field positions in the channel 5 data nibbles (BIT_INHIBIT: channel 4)
	localparam int unsigned BIT_HALF_FLAG  = 0;
	localparam int unsigned BIT_WAVE_10HZ  = 1;
	localparam int unsigned BIT_WAVE_100HZ = 2;
	localparam int unsigned BIT_FLAG_CLEAR = 0;
	localparam int unsigned BIT_PHASE_CLR  = 1;
	localparam int unsigned BIT_BROWNOUT   = 0;
	localparam int unsigned BIT_INHIBIT    = 0;
	// Values after reset, and the selector value that turns the synthesizer off
	localparam logic       HALF_FLAG_RST = 1'b1;
	localparam logic [3:0] TEST_PORT_RST = 4'h0;
	localparam logic [3:0] REF_SEL_OFF   = 4'hf;
	// Timing: the fastest chain tick is every 5 ms
	localparam int unsigned SYS_PERIOD_PS = 10_000;
	localparam int unsigned TICK_5MS_US   = 5_000;
	// Reckoned in ns so that the product stays inside 32 bits
	localparam int unsigned PRESCALE_CYC  = (TICK_5MS_US * 1_000) / (SYS_PERIOD_PS / 1_000);
	// Decade stages: 200 Hz -> 100 Hz -> 20 Hz -> 2 Hz
	localparam int unsigned DIV_100HZ = 2;
	localparam int unsigned DIV_20HZ  = 5;
	localparam int unsigned DIV_2HZ   = 10;
	// Operating modes of the device
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_HALT,
		MODE_STOP
	} tbs_mode_t;
endpackage

// >>> hw/tbs_timebase.sv
// Time base, half-second flag, brown-out halt, clock stop and test port
// Operation
// - half-second flag set every 500 ms
// - IO out channel 5 bit clears flag
// - IO in channel 5 reads flag
// - flag undefined after power-up and clock stop
// - 10 ms and 100 ms square waves, 50%
// - wave bits read directly, unlatched
// - phase clear resets 50 Hz and slower
// - restarted slow time base within -0.02 s
// - supply low halts and sets brown-out flag
// - key in channel 5 reads brown-out flag
// - flag clear bit also clears brown-out
// - halted device keeps state, runs nothing; the time base keeps running while halted
// - inhibit level readable on IO channel 4
// - clock-stop with inhibit low stops clock
// - selector all ones turns synthesizer off
// - clock stop forces outputs low, latches kept
`timescale 1ns/1ps
module tbs_timebase
	import tbs_pkg::*;
#(
	parameter int unsigned PRESCALE = PRESCALE_CYC
) (
	// Clock, reset, enable
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic       clk_en,
	// CPU port instruction
	input  wire logic       port_strobe,
	input  wire logic [1:0] port_op,
	input  wire logic [3:0] channel_operand,
	input  wire logic [3:0] port_wdata,
	output logic [3:0]      port_rdata,
	output logic            port_rvalid,
	// Clock-stop instruction and pins
	input  wire logic       clock_stop_instruction,
	input  wire logic       inhibit_input,
	input  wire logic       supply_low,
	input  wire logic [3:0] ref_selector,
	// Device state
	output logic            cpu_halt,
	output logic            clock_stopped,
	output logic            outputs_force_low,
	output logic            synth_off,
	output logic [3:0]      factory_test_port
);
	function automatic logic hit(input logic [1:0] op, input logic [3:0] ch,
			input logic [1:0] want_op, input logic [3:0] want_ch);
		return (op == want_op) && (ch == want_ch);
	endfunction

	tbs_mode_t mode_reg;
	logic      half_flag_reg;
	logic      brownout_reg;
	logic      wave_100hz_reg;
	logic      wave_10hz_reg;
	logic      running;
	logic      accept;
	logic      wr_tb_ctl;
	logic      flag_clear;
	logic      phase_clear;
	logic [4:0] tick;

	// Time base freezes with the crystal in clock stop
	assign running     = clk_en && (mode_reg != MODE_STOP);
	// No instruction executes while halted or stopped
	assign accept      = clk_en && (mode_reg == MODE_RUN) && port_strobe;
	assign wr_tb_ctl   = accept && hit(port_op, channel_operand, OP_IO_OUT, CH_TIMEBASE);
	assign flag_clear  = wr_tb_ctl && port_wdata[BIT_FLAG_CLEAR];
	assign phase_clear = wr_tb_ctl && port_wdata[BIT_PHASE_CLR];
	assign tick[0]     = 1'b1;

	// Chain: 5 ms prescaler, /2 for 100 Hz, /5 for 20 Hz, /10 for 2 Hz
	localparam int unsigned MODS [4] = '{PRESCALE, DIV_100HZ, DIV_20HZ, DIV_2HZ};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chain
			tbs_div_stage #(
				.MODULUS (MODS[gi])
			) u_stage (
				.sys_clk  (sys_clk),
				.arst_n   (arst_n),
				.en       (running),
				.clear    ((gi >= 2) ? phase_clear : 1'b0),
				.tick_in  (tick[gi]),
				.tick_out (tick[gi+1])
			);
		end
	endgenerate

	// Square waves toggle on each half period
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wave_100hz_reg <= 1'b0;
			wave_10hz_reg  <= 1'b0;
		end else if (running) begin
			if (tick[1])
				wave_100hz_reg <= !wave_100hz_reg;
			if (phase_clear)
				wave_10hz_reg <= 1'b0;
			else if (tick[3])
				wave_10hz_reg <= !wave_10hz_reg;
		end
	end

	// Half-second flag: a set arriving with the clear wins
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			half_flag_reg <= HALF_FLAG_RST;
		end else if (running) begin
			if (tick[4])
				half_flag_reg <= 1'b1;
			else if (flag_clear)
				half_flag_reg <= 1'b0;
		end
	end

	// Brown-out flag
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			brownout_reg <= 1'b0;
		end else if (clk_en) begin
			if (supply_low && mode_reg != MODE_STOP)
				brownout_reg <= 1'b1;
			else if (flag_clear)
				brownout_reg <= 1'b0;
		end
	end

	// Operating mode
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= MODE_RUN;
		end else if (clk_en) begin
			case (mode_reg)
				MODE_RUN: begin
					if (supply_low)
						mode_reg <= MODE_HALT;
					else if (clock_stop_instruction && !inhibit_input)
						mode_reg <= MODE_STOP;
				end
				MODE_HALT: begin
					if (!supply_low)
						mode_reg <= MODE_RUN;
				end
				MODE_STOP: begin
					if (inhibit_input)
						mode_reg <= MODE_RUN;
				end
				default: mode_reg <= MODE_RUN;
			endcase
		end
	end

	// Registered device-state outputs
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_halt          <= 1'b0;
			clock_stopped     <= 1'b0;
			outputs_force_low <= 1'b0;
			synth_off         <= 1'b0;
		end else if (clk_en) begin
			cpu_halt          <= (mode_reg == MODE_HALT);
			clock_stopped     <= (mode_reg == MODE_STOP);
			outputs_force_low <= (mode_reg == MODE_STOP);
			synth_off         <= (ref_selector == REF_SEL_OFF);
		end
	end

	// Test port latch
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			factory_test_port <= TEST_PORT_RST;
		else if (accept && hit(port_op, channel_operand, OP_KEY_OUT, CH_TEST))
			factory_test_port <= port_wdata;
	end

	// Read answers, one cycle after the strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_rdata  <= 4'h0;
			port_rvalid <= 1'b0;
		end else if (clk_en) begin
			port_rvalid <= accept && (port_op == OP_IO_IN || port_op == OP_KEY_IN);
			port_rdata  <= 4'h0;
			if (accept && hit(port_op, channel_operand, OP_IO_IN, CH_TIMEBASE)) begin
				port_rdata[BIT_HALF_FLAG]  <= half_flag_reg;
				port_rdata[BIT_WAVE_10HZ]  <= wave_10hz_reg;
				port_rdata[BIT_WAVE_100HZ] <= wave_100hz_reg;
			end else if (accept && hit(port_op, channel_operand, OP_IO_IN, CH_INHIBIT)) begin
				port_rdata[BIT_INHIBIT] <= inhibit_input;
			end else if (accept && hit(port_op, channel_operand, OP_KEY_IN, CH_TIMEBASE)) begin
				port_rdata[BIT_BROWNOUT] <= brownout_reg;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_req(logic [1:0] op, logic [3:0] ch);
		accept && port_op == op && channel_operand == ch;
	endsequence

	property p_flag_set;
		running && tick[4] |=> half_flag_reg;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("half flag not set");

	property p_flag_clr;
		running && flag_clear && !tick[4] |=> !half_flag_reg;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("half flag not cleared");

	property p_rd_flag;
		s_req(OP_IO_IN, CH_TIMEBASE) |=> port_rvalid && port_rdata[0] == $past(half_flag_reg);
	endproperty
	a_rd_flag: assert property (p_rd_flag) else $error("bad flag read");

	property p_wave100;
		$changed(wave_100hz_reg) |-> $past(tick[1]) && $past(running);
	endproperty
	a_wave100: assert property (p_wave100) else $error("100 Hz wave off tick");

	property p_phase;
		clk_en && mode_reg != MODE_STOP && phase_clear |=> !wave_10hz_reg && !tick[3];
	endproperty
	a_phase: assert property (p_phase) else $error("phase clear missed");

	property p_halt;
		clk_en && mode_reg == MODE_RUN && supply_low |=> mode_reg == MODE_HALT && brownout_reg
			##1 (cpu_halt || !$past(clk_en));
	endproperty
	a_halt: assert property (p_halt) else $error("brown-out halt missed");

	property p_rd_brown;
		s_req(OP_KEY_IN, CH_TIMEBASE) |=> port_rdata[0] == $past(brownout_reg);
	endproperty
	a_rd_brown: assert property (p_rd_brown) else $error("bad brown-out read");

	property p_brown_clr;
		flag_clear && !supply_low |=> !brownout_reg;
	endproperty
	a_brown_clr: assert property (p_brown_clr) else $error("brown-out not cleared");

	property p_halt_quiet;
		clk_en && mode_reg == MODE_HALT && port_strobe |=> $stable(factory_test_port)
			&& !port_rvalid;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("access while halted");

	property p_rd_inh;
		s_req(OP_IO_IN, CH_INHIBIT) |=> port_rdata[0] == $past(inhibit_input);
	endproperty
	a_rd_inh: assert property (p_rd_inh) else $error("bad inhibit read");

	property p_stop;
		clk_en && mode_reg == MODE_RUN && !supply_low && clock_stop_instruction
			&& !inhibit_input |=> mode_reg == MODE_STOP;
	endproperty
	a_stop: assert property (p_stop) else $error("clock stop missed");

	property p_synth;
		clk_en && ref_selector == REF_SEL_OFF |=> synth_off;
	endproperty
	a_synth: assert property (p_synth) else $error("synth off missed");

	property p_force;
		clk_en |=> outputs_force_low == ($past(mode_reg) == MODE_STOP);
	endproperty
	a_force: assert property (p_force) else $error("force low wrong");
endmodule // tbs_timebase

// >>> verif/tbs_cpu_model.sv
// CPU core model issuing port and clock-stop instructions
`timescale 1ns/1ps
module tbs_cpu_model (
	// Clock
	input  wire logic       sys_clk,
	// Port bus
	output logic            port_strobe,
	output logic [1:0]      port_op,
	output logic [3:0]      channel_operand,
	output logic [3:0]      port_wdata,
	input  wire logic [3:0] port_rdata,
	input  wire logic       port_rvalid,
	// Clock stop
	output logic            clock_stop_instruction
);
	initial begin
		port_strobe = 1'b0;
		port_op = 2'h0;
		channel_operand = 4'h0;
		port_wdata = 4'h0;
		clock_stop_instruction = 1'b0;
	end
	// Idle channel and data lines carry the inverse of the last value; port_op keeps it
	task automatic xfer(input logic [1:0] op, input logic [3:0] ch,
			input logic [3:0] wd, output logic [3:0] rd, output logic rv);
		@(negedge sys_clk);
		port_strobe = 1'b1;
		port_op = op;
		channel_operand = ch;
		port_wdata = wd;
		@(negedge sys_clk);
		rd = port_rdata;
		rv = port_rvalid;
		port_strobe = 1'b0;
		channel_operand = ~ch;
		port_wdata = ~wd;
	endtask
	task automatic stop_clock();
		@(negedge sys_clk);
		clock_stop_instruction = 1'b1;
		@(negedge sys_clk);
		clock_stop_instruction = 1'b0;
	endtask
endmodule // tbs_cpu_model

// >>> verif/tbs_timebase_tb.sv
// Self-checking bench for the time base and status ports
`timescale 1ns/1ps
module tbs_timebase_tb;
	import tbs_pkg::*;
	localparam int unsigned PS = 4;
	// Clock reset may bring the slow base up to 0.02 s early; plus pipeline and polling
	localparam int unsigned FLAG_MIN = 96 * PS;
	localparam int unsigned FLAG_MAX = 100 * PS + 4;
	logic       sys_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       clk_en = 1'b1;
	logic       inhibit_input = 1'b1;
	logic       supply_low = 1'b0;
	logic [3:0] ref_selector = 4'h0;
	logic       port_strobe, port_rvalid, clock_stop_instruction, rv;
	logic       cpu_halt, clock_stopped, outputs_force_low, synth_off;
	logic [1:0] port_op;
	logic [3:0] channel_operand, port_wdata, port_rdata, factory_test_port, rd;
	int         mismatches = 0;
	int         checked = 0;
	int         cycles = 0;
	int         n10, n100, t0;
	logic       p10, p100;
	always #5 sys_clk = ~sys_clk;
	tbs_timebase #(.PRESCALE(PS)) tbs_timebase_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.clk_en(clk_en), .port_strobe(port_strobe), .port_op(port_op),
		.channel_operand(channel_operand), .port_wdata(port_wdata),
		.port_rdata(port_rdata), .port_rvalid(port_rvalid),
		.clock_stop_instruction(clock_stop_instruction), .inhibit_input(inhibit_input),
		.supply_low(supply_low), .ref_selector(ref_selector), .cpu_halt(cpu_halt),
		.clock_stopped(clock_stopped), .outputs_force_low(outputs_force_low),
		.synth_off(synth_off), .factory_test_port(factory_test_port));
	tbs_cpu_model tbs_cpu_model_i (.sys_clk(sys_clk), .port_strobe(port_strobe),
		.port_op(port_op), .channel_operand(channel_operand), .port_wdata(port_wdata),
		.port_rdata(port_rdata), .port_rvalid(port_rvalid),
		.clock_stop_instruction(clock_stop_instruction));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_nib(string nm, logic [3:0] exp, logic [3:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic chk_bit(string nm, logic exp, logic got);
		chk_nib(nm, {3'h0, exp}, {3'h0, got});
	endtask
	task automatic chk_rng(string nm, int lo, int hi, int got);
		checked++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
		end
	endtask
	task automatic wr(logic [1:0] op, logic [3:0] ch, logic [3:0] wd);
		tbs_cpu_model_i.xfer(op, ch, wd, rd, rv);
	endtask
	task automatic rd_chk(string nm, logic [1:0] op, logic [3:0] ch, logic [3:0] m,
			logic [3:0] exp);
		tbs_cpu_model_i.xfer(op, ch, 4'h0, rd, rv);
		chk_bit("rvalid", 1'b1, rv);
		chk_nib(nm, exp, rd & m);
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		arst_n = 1'b1;
		rd_chk("half flag", OP_IO_IN, CH_TIMEBASE, 4'h1, {3'h0, HALF_FLAG_RST});
		rd_chk("brown-out", OP_KEY_IN, CH_TIMEBASE, 4'hf, 4'h0);
		chk_nib("test port", TEST_PORT_RST, factory_test_port);
		chk_bit("synth on", 1'b0, synth_off);
		rd_chk("inhibit hi", OP_IO_IN, CH_INHIBIT, 4'hf, 4'h1);
		inhibit_input = 1'b0;
		rd_chk("inhibit lo", OP_IO_IN, CH_INHIBIT, 4'hf, 4'h0);
		rd_chk("unused ch", OP_IO_IN, 4'h3, 4'hf, 4'h0);
		// Flag clear and phase clear in one write
		wr(OP_IO_OUT, CH_TIMEBASE, 4'h3);
		t0 = cycles;
		rd_chk("cleared", OP_IO_IN, CH_TIMEBASE, 4'h3, 4'h0);
		n10 = 0;
		n100 = 0;
		p10 = rd[1];
		p100 = rd[2];
		while (rd[0] !== 1'b1 && cycles - t0 < 500) begin
			wr(OP_IO_IN, CH_TIMEBASE, 4'h0);
			n10 += int'(rd[1] !== p10);
			n100 += int'(rd[2] !== p100);
			p10 = rd[1];
			p100 = rd[2];
		end
		chk_rng("flag set", FLAG_MIN, FLAG_MAX, cycles - t0);
		chk_rng("100Hz edges", 97, 102, n100);
		chk_rng("10Hz edges", 9, 11, n10);
		wr(OP_IO_OUT, CH_TIMEBASE, 4'h1);
		wr(OP_KEY_OUT, CH_TEST, 4'ha);
		chk_nib("test port", 4'ha, factory_test_port);
		// Enable low freezes every flop, port latch included
		clk_en = 1'b0;
		wr(OP_KEY_OUT, CH_TEST, 4'h5);
		chk_nib("frozen port", 4'ha, factory_test_port);
		clk_en = 1'b1;
		// Brown-out halt ignores instructions
		supply_low = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk_bit("halt", 1'b1, cpu_halt);
		wr(OP_KEY_OUT, CH_TEST, 4'h5);
		chk_nib("held port", 4'ha, factory_test_port);
		supply_low = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk_bit("resume", 1'b0, cpu_halt);
		rd_chk("brown-out", OP_KEY_IN, CH_TIMEBASE, 4'h1, 4'h1);
		wr(OP_IO_OUT, CH_TIMEBASE, 4'h1);
		rd_chk("bo cleared", OP_KEY_IN, CH_TIMEBASE, 4'h1, 4'h0);
		// Clock stop, refused while inhibit is high
		ref_selector = REF_SEL_OFF;
		@(negedge sys_clk);
		chk_bit("synth off", 1'b1, synth_off);
		inhibit_input = 1'b1;
		tbs_cpu_model_i.stop_clock();
		repeat (3) @(negedge sys_clk);
		chk_bit("no stop", 1'b0, clock_stopped);
		inhibit_input = 1'b0;
		rd_chk("inhibit ok", OP_IO_IN, CH_INHIBIT, 4'hf, 4'h0);
		tbs_cpu_model_i.stop_clock();
		repeat (3) @(negedge sys_clk);
		chk_bit("stopped", 1'b1, clock_stopped);
		chk_bit("force low", 1'b1, outputs_force_low);
		chk_nib("latch kept", 4'ha, factory_test_port);
		inhibit_input = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk_bit("restart", 1'b0, clock_stopped);
		chk_bit("release", 1'b0, outputs_force_low);
		wr(OP_KEY_OUT, CH_TEST, TEST_PORT_RST);
		chk_nib("test port", 4'h0, factory_test_port);
		finish_test();
	end
endmodule // tbs_timebase_tb
